/* File: sim/fcr_flash_engine_model.sv */
// behavioural flash array engine facing the register block
// assumes op_req pulses for one clk_sys cycle and one operation runs at a time
`timescale 1ns/1ps
module fcr_flash_engine_model #(
  parameter int DELAY = 12
) (
  input  wire logic             clk_sys,
  input  wire logic             resetn,
  input  wire fcr_pkg::fcr_op_t op_req,
  input  wire logic             not_blank,
  output logic                  op_done,
  output logic                  op_not_blank
);
  logic       run;
  logic [4:0] cnt;

  // ----------------------------------------------------------------
  // fixed-latency engine
  // ----------------------------------------------------------------
  // the blank flag toggles outside its done cycle so a design that samples it
  // at the wrong moment sees garbage instead of a lucky steady value
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      run          <= 1'b0;
      cnt          <= 5'd0;
      op_done      <= 1'b0;
      op_not_blank <= 1'b0;
    end else begin
      op_done      <= 1'b0;
      op_not_blank <= ~op_not_blank;
      if (op_req.valid) begin
        run <= 1'b1;
        cnt <= 5'(DELAY);
      end else if (run) begin
        if (cnt == 5'd0) begin
          run          <= 1'b0;
          op_done      <= 1'b1;
          op_not_blank <= not_blank; // only meaningful with op_done
        end else begin
          cnt <= cnt - 5'd1;
        end
      end
    end
  end
endmodule

/* File: sim/fcr_flash_regs_tb.sv */
// self-checking bench of the flash control register block
// assumes the axi4-lite slave and engine model share clk_sys
`timescale 1ns/1ps
module fcr_flash_regs_tb;
  localparam logic [31:0] K1  = 32'h1111_2222;
  localparam logic [31:0] K2  = 32'h3333_4444;
  localparam logic [31:0] PRODUCT_CODE = 32'h5EED_0042; // arbitrary value
  localparam logic [1:0]  OK  = fcr_pkg::RESP_OKAY;
  localparam logic [1:0]  SE  = fcr_pkg::RESP_SLVERR;
  typedef struct packed {logic wr; logic [11:0] a; logic [31:0] d; logic [1:0] r;} fcr_row_t;
  // ----------------------------------------------------------------
  // ordinary cases: reads give expected data, writes give expected response
  // ----------------------------------------------------------------
  localparam fcr_row_t ROWS [22] = '{
    '{1'b0, 12'h00C, 32'h0000_0000, OK}, '{1'b0, 12'h010, 32'h0000_0080, OK},
    '{1'b0, 12'h014, 32'h0000_0000, OK}, '{1'b0, 12'h004, 32'h0000_0000, OK},
    '{1'b0, 12'h008, 32'h0000_0000, OK}, '{1'b0, 12'h100, PRODUCT_CODE, OK},
    '{1'b0, 12'h01C, 32'h3412_3C00, OK}, '{1'b0, 12'h020, 32'h0000_FFFE, OK},
    '{1'b0, 12'h030, 32'h0000_0000, SE}, '{1'b1, 12'h030, 32'h0000_0001, SE},
    '{1'b1, 12'h010, 32'h0000_1401, OK}, '{1'b0, 12'h010, 32'h0000_0080, OK},
    '{1'b1, 12'h004, K1, OK},            '{1'b1, 12'h004, K2, OK},
    '{1'b0, 12'h010, 32'h0000_0000, OK}, '{1'b1, 12'h014, 32'h0000_1000, OK},
    '{1'b0, 12'h014, 32'h0000_1000, OK}, '{1'b1, 12'h008, K1, OK},
    '{1'b1, 12'h008, K2, OK},            '{1'b0, 12'h010, 32'h0000_0200, OK},
    '{1'b1, 12'h010, 32'h0000_0000, OK}, '{1'b0, 12'h010, 32'h0000_0000, OK}};

  logic                  clk_sys;
  logic                  resetn;
  fcr_pkg::fcr_axi_req_t req;
  fcr_pkg::fcr_axi_rsp_t rsp;
  fcr_pkg::fcr_prog_t    prog_req;
  fcr_pkg::fcr_op_t      op_req;
  fcr_pkg::fcr_op_t      last_op;
  logic                  op_done;
  logic                  op_not_blank;
  logic                  nb;
  logic [11:0][7:0]      opt_bytes;
  logic [2:0]            wait_count;
  logic                  irq_done;
  logic                  irq_error;
  logic                  sys_reset_req;
  logic [31:0]           d;
  logic [1:0]            r;
  int                    n_fail;
  int                    cmp_count;
  int                    n_op;
  int                    n_rst;
  int                    k;

  fcr_flash_regs #(.UNLOCK_KEY1(K1), .UNLOCK_KEY2(K2), .PRODUCT_ID(PRODUCT_CODE), .PAGE_SHIFT(10))
  fcr_flash_regs_i (.clk_sys(clk_sys), .resetn(resetn), .axi_req(req), .axi_rsp(rsp),
    .prog_req(prog_req), .prog_ready(), .op_req(op_req), .op_done(op_done),
    .op_not_blank(op_not_blank), .opt_bytes(opt_bytes), .wait_count(wait_count),
    .irq_done(irq_done), .irq_error(irq_error), .sys_reset_req(sys_reset_req));

  fcr_flash_engine_model fcr_flash_engine_model_i (.clk_sys(clk_sys), .resetn(resetn),
    .op_req(op_req), .not_blank(nb), .op_done(op_done), .op_not_blank(op_not_blank));

  // clock and watchdog; the watchdog span is far above the few hundred cycles used
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    #500000;
    n_fail++;
    results();
  end
  // launched operations and reset requests seen at the engine side
  always @(posedge clk_sys) begin
    if (op_req.valid === 1'b1) begin
      last_op <= op_req;
      n_op++;
    end
    if (sys_reset_req === 1'b1) n_rst++;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one write; bready stays high for the whole run so no task toggles it
  task automatic axw(input logic [11:0] a, input logic [31:0] wd, output logic [1:0] br);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    req.awvalid <= 1'b1;
    req.awaddr <= {20'h0_0000, a};
    req.wvalid <= 1'b1;
    req.wdata <= wd;
    req.wstrb <= 4'hF;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk_sys);
      if (!aw_ok && rsp.awready === 1'b1) begin
        aw_ok = 1'b1;
        req.awvalid <= 1'b0;
      end
      if (!w_ok && rsp.wready === 1'b1) begin
        w_ok = 1'b1;
        req.wvalid <= 1'b0;
      end
    end
    do @(posedge clk_sys); while (rsp.bvalid !== 1'b1);
    br = rsp.bresp;
  endtask
  task automatic axr(input logic [11:0] a, output logic [31:0] rd, output logic [1:0] rr);
    req.arvalid <= 1'b1;
    req.araddr <= {20'h0_0000, a};
    do @(posedge clk_sys); while (rsp.arready !== 1'b1);
    req.arvalid <= 1'b0;
    do @(posedge clk_sys); while (rsp.rvalid !== 1'b1);
    rd = rsp.rdata;
    rr = rsp.rresp;
  endtask
  task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] e);
    axr(a, d, r);
    chk(nm, e, d);
    chk({nm, " resp"}, {30'h0, OK}, {30'h0, r});
  endtask
  task automatic prg(input logic h, input logic [31:0] a);
    prog_req <= '{1'b1, h, a, 32'h0000_BEEF};
    @(posedge clk_sys);
    prog_req.valid <= 1'b0;
  endtask
  // wait for idle, check flags, kind and interrupts, then clear all flags
  task automatic opw(input logic [2:0] kd, input logic [31:0] s, input logic [1:0] irq);
    d = 32'h0000_0001;
    while (d[0] !== 1'b0) axr(12'h00C, d, r);
    chk("stat", s, d);
    chk("kind", {29'h0, kd}, {29'h0, last_op.kind});
    chk("irq", {30'h0, irq}, {30'h0, irq_done, irq_error});
    axw(12'h00C, 32'h0000_003C, r);
    chk("irq clr", 32'h0, {30'h0, irq_done, irq_error});
  endtask
  task automatic results();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    resetn = 1'b0;
    req = '0;
    req.bready = 1'b1;
    req.rready = 1'b1;
    prog_req = '0;
    nb = 1'b0;
    opt_bytes = {8'h00, 8'hFF, 8'h01, 8'hFE, 8'hCB, 8'h34, 8'hED, 8'h12, 8'hC3, 8'h3C,
                 8'h5A, 8'hA5};
    repeat (3) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (2) @(posedge clk_sys);
    foreach (ROWS[i]) begin
      if (ROWS[i].wr) axw(ROWS[i].a, ROWS[i].d, r);
      else axr(ROWS[i].a, d, r);
      if (!ROWS[i].wr) chk($sformatf("row %0d", i), ROWS[i].d, d);
      chk($sformatf("row %0d resp", i), {30'h0, ROWS[i].r}, {30'h0, r});
    end
    $display("test table done");
    for (int i = 0; i < 3; i++) begin
      axw(12'h000, i, r);
      chk("wait_count", i, {29'h0, wait_count});
    end
    $display("test wait states done");
    axw(12'h010, 32'h0000_1002, r);
    axw(12'h010, 32'h0000_1042, r);
    rdc("busy", 12'h00C, 32'h0000_0001);
    opw(fcr_pkg::OP_PER, 32'h0000_0020, 2'b10);
    chk("op addr", 32'h0000_1000, last_op.addr);
    rdc("start clr", 12'h010, 32'h0000_1002);
    k = n_op;
    axw(12'h014, 32'h0000_0000, r);
    axw(12'h010, 32'h0000_0442, r);
    opw(fcr_pkg::OP_PER, 32'h0000_0010, 2'b01);
    chk("no op", k, n_op);
    $display("test erase done");
    axw(12'h010, 32'h0000_0401, r);
    prg(1'b0, 32'h0000_1002);
    opw(fcr_pkg::OP_PER, 32'h0000_0008, 2'b00);
    nb = 1'b1;
    prg(1'b0, 32'h0000_1004);
    opw(fcr_pkg::OP_PG, 32'h0000_0004, 2'b01);
    nb = 1'b0;
    prg(1'b1, 32'h0000_1006);
    opw(fcr_pkg::OP_PG, 32'h0000_0020, 2'b00);
    $display("test program done");
    axw(12'h008, K1, r);
    axw(12'h008, K2, r);
    axw(12'h010, 32'h0000_0260, r);
    opw(fcr_pkg::OP_OPTION_ERASE_CMD, 32'h0000_0020, 2'b00);
    axw(12'h010, 32'h0000_0210, r);
    prg(1'b0, 32'h0000_0000);
    opw(fcr_pkg::OP_OPTION_PROGRAM_CMD, 32'h0000_0020, 2'b00);
    axw(12'h010, 32'h0000_0044, r);
    opw(fcr_pkg::OP_OPTION_PROGRAM_CMD, 32'h0000_0010, 2'b00);
    $display("test option and mass done");
    opt_bytes[1] <= 8'h00;
    k = n_rst;
    axw(12'h010, 32'h0000_2000, r);
    repeat (2) @(posedge clk_sys);
    chk("reset req", k + 1, n_rst);
    rdc("reload", 12'h01C, 32'h3412_3C03);
    axw(12'h010, 32'h0000_0080, r);
    rdc("relock", 12'h010, 32'h0000_0080);
    $display("test reload done");
    resetn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rdc("ctl reset", 12'h010, 32'h0000_0080);
    chk("ws reset", 32'h0, {29'h0, wait_count});
    $display("test reset done");
    results();
  end
endmodule

/* File: verilog/fcr_flash_regs.sv */
// register block of the embedded flash controller, axi4-lite slave
// assumes flash engine, option bytes and program writes share clk_sys
//
// What this block does
// (R1) wait code 000/001/010 adds 0/1/2 states
// (R2) key pair clears lock; software sets lock
// (R3) option key pair sets option write enable
// (R4) success sets done flag; write 1 clears
// (R5) protected target sets protect error; w1c
// (R6) misaligned program write sets align error; w1c
// (R7) program over non-blank sets program error; w1c
// (R8) busy high during operation, low after
// (R9) control resets to 0x80, locked
// (R10) reload bit reloads options, requests system reset
// (R11) done interrupt only when its enable set
// (R12) error interrupt only when its enable set
// (R13) start launches erase; cleared when busy clears
// (R14) bits 5/4 are option erase/program commands
// (R15) bits 2/1/0 mass, page erase, program
// (R16) command address register targets erase commands
// (R17) option status shows user data and byte
// (R18) security level coded 00/01/11 at 2:1
// (R19) option mismatch sets flag, forces 0xFF
// (R20) write-protect view loaded from option bits
// (R21) read-only product identifier at 0x100
// (R22) software uses full-word accesses on listed registers
// (R23) protected pages are never erased or programmed
// (R24) lock freezes command, start, interrupt enable bits
// (R25) interrupts are flag and enable combinations
// (R26) key registers read back zero
//
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
module fcr_flash_regs #(
  parameter logic [31:0] UNLOCK_KEY1 = 32'h1111_2222,
  parameter logic [31:0] UNLOCK_KEY2 = 32'h3333_4444,
  parameter logic [31:0] PRODUCT_ID  = 32'h0000_0001, // arbitrary value
  parameter int          PAGE_SHIFT  = 10
) (
  input  wire logic                 clk_sys,
  input  wire logic                 resetn,
  input  wire fcr_pkg::fcr_axi_req_t axi_req,
  output fcr_pkg::fcr_axi_rsp_t     axi_rsp,
  input  wire fcr_pkg::fcr_prog_t   prog_req,
  output logic                      prog_ready,
  output fcr_pkg::fcr_op_t          op_req,
  input  wire logic                 op_done,
  input  wire logic                 op_not_blank,
  input  wire logic [11:0][7:0]     opt_bytes,
  output logic [2:0]                wait_count,
  output logic                      irq_done,
  output logic                      irq_error,
  output logic                      sys_reset_req
);

  fcr_pkg::fcr_state_t q, d;
  logic [5:0][8:0]     obp;
  logic                wr_go;
  logic                busy;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // byte-lane merge; narrow writes touch only their lanes
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) r[8*i +: 8] = n[8*i +: 8];
    end
    return r;
  endfunction

  // option byte with its complement; mismatch yields 0xFF and flag
  function automatic logic [8:0] ob_pick(input logic [7:0] v, input logic [7:0] c);
    return (v == ~c) ? {1'b0, v} : {1'b1, 8'hFF};
  endfunction

  // four pages per protect bit; a zero bit protects them
  function automatic logic is_prot(input logic [31:0] a, input logic [15:0] wp);
    return ~wp[a[PAGE_SHIFT+2 +: 4]];
  endfunction

  for (genvar i = 0; i < 6; i++) begin : g_ob
    assign obp[i] = ob_pick(opt_bytes[2*i], opt_bytes[2*i+1]); // R19
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign busy        = (q.fsm == fcr_pkg::FSM_BUSY);
  assign wr_go       = q.aw_v && q.w_v && !q.b_v;
  assign prog_ready  = !busy;
  assign op_req      = q.op;
  assign wait_count  = q.wcnt; // R1
  assign sys_reset_req = q.rst_req;
  // interrupt lines straight from sticky flags and enables
  assign irq_done  = q.stat[fcr_pkg::ST_OP_DONE_FLAG] && q.ctl[fcr_pkg::CTL_DONE_IRQ_ENABLE]; // R11 R25
  assign irq_error = (q.stat[fcr_pkg::ST_PROTECT_ERROR_FLAG] || q.stat[fcr_pkg::ST_PROGRAM_ERROR_FLAG])
                     && q.ctl[fcr_pkg::CTL_ERROR_IRQ_ENABLE]; // R12 R25
  assign axi_rsp.awready = !q.aw_v;
  assign axi_rsp.wready  = !q.w_v;
  assign axi_rsp.bvalid  = q.b_v;
  assign axi_rsp.bresp   = q.b_r;
  assign axi_rsp.arready = !q.r_v;
  assign axi_rsp.rvalid  = q.r_v;
  assign axi_rsp.rdata   = q.r_d;
  assign axi_rsp.rresp   = q.r_r;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  // software effects first, hardware events after, so a set wins
  always_comb begin
    logic [31:0] wd;
    logic [31:0] cd;
    logic        lk;
    wd = 32'h0000_0000;
    cd = 32'h0000_0000;
    lk = q.ctl[fcr_pkg::CTL_LK];
    d  = q;
    d.rst_req  = 1'b0;
    d.op.valid = 1'b0;

    // option bytes captured after reset release or on reload
    if (q.opt_load) begin
      d.opt_load = 1'b0;
      d.obstat   = {obp[3][7:0], obp[2][7:0], obp[1][7:0], 5'h00, 2'h1,
                    obp[0][8] | obp[1][8] | obp[2][8] | obp[3][8] | obp[4][8] | obp[5][8]};
      if (obp[0][7:0] == fcr_pkg::SPC_NONE) d.obstat[2:1] = 2'h0; // R18
      if (obp[0][7:0] == fcr_pkg::SPC_HIGH) d.obstat[2:1] = 2'h3; // R18
      d.wp = {obp[5][7:0], obp[4][7:0]}; // R20 R17
    end

    // write address and data are taken independently
    if (axi_req.awvalid && !q.aw_v) begin
      d.aw_v = 1'b1;
      d.aw_a = axi_req.awaddr[11:0];
    end
    if (axi_req.wvalid && !q.w_v) begin
      d.w_v = 1'b1;
      d.w_d = axi_req.wdata;
      d.w_s = axi_req.wstrb;
    end
    if (q.b_v && axi_req.bready) d.b_v = 1'b0;

    if (wr_go) begin
      d.aw_v = 1'b0;
      d.w_v  = 1'b0;
      d.b_v  = 1'b1;
      d.b_r  = fcr_pkg::RESP_OKAY;
      // key words only count as whole words; a partial one restarts the pair
      case (q.aw_a)
        fcr_pkg::OFF_WS: begin
          wd = merge({29'h0, q.wcnt}, q.w_d, q.w_s);
          d.wcnt = wd[2:0]; // R1
        end
        fcr_pkg::OFF_KEY: begin
          d.key_half = (q.w_s == 4'hF) && !q.key_half && (q.w_d == UNLOCK_KEY1);
          if ((q.w_s == 4'hF) && q.key_half && (q.w_d == UNLOCK_KEY2)) begin
            d.ctl[fcr_pkg::CTL_LK] = 1'b0; // R2
          end
        end
        fcr_pkg::OFF_OPTION_KEY_VALUE: begin
          d.okey_half = (q.w_s == 4'hF) && !q.okey_half && (q.w_d == UNLOCK_KEY1);
          if ((q.w_s == 4'hF) && q.okey_half && (q.w_d == UNLOCK_KEY2)) begin
            d.ctl[fcr_pkg::CTL_OPTION_WRITE_ENABLE] = 1'b1; // R3
          end
        end
        fcr_pkg::OFF_STAT: begin
          if (q.w_s[0]) d.stat[5:2] = q.stat[5:2] & ~q.w_d[5:2]; // R4 R5 R6 R7
        end
        fcr_pkg::OFF_CTL: begin
          cd = merge({18'h0, q.ctl}, q.w_d, q.w_s);
          if (cd[fcr_pkg::CTL_LK]) d.ctl[fcr_pkg::CTL_LK] = 1'b1; // R2
          if (!cd[fcr_pkg::CTL_OPTION_WRITE_ENABLE]) d.ctl[fcr_pkg::CTL_OPTION_WRITE_ENABLE] = 1'b0; // R3
          if (cd[fcr_pkg::CTL_OPTION_RELOAD]) begin
            d.opt_load = 1'b1; // R10
            d.rst_req  = 1'b1; // R10
          end
          // locked: command, start and interrupt enable bits keep their values
          if (!lk) begin // R24
            d.ctl[fcr_pkg::CTL_PG]    = cd[fcr_pkg::CTL_PG]; // R15
            d.ctl[fcr_pkg::CTL_PER]   = cd[fcr_pkg::CTL_PER]; // R15
            d.ctl[fcr_pkg::CTL_MER]   = cd[fcr_pkg::CTL_MER]; // R15
            d.ctl[fcr_pkg::CTL_ERROR_IRQ_ENABLE] = cd[fcr_pkg::CTL_ERROR_IRQ_ENABLE];
            d.ctl[fcr_pkg::CTL_DONE_IRQ_ENABLE] = cd[fcr_pkg::CTL_DONE_IRQ_ENABLE];
            if (cd[fcr_pkg::CTL_START]) d.ctl[fcr_pkg::CTL_START] = 1'b1; // R13
            // option commands need the option write enable
            if (q.ctl[fcr_pkg::CTL_OPTION_WRITE_ENABLE]) begin
              d.ctl[fcr_pkg::CTL_OPTION_PROGRAM_CMD] = cd[fcr_pkg::CTL_OPTION_PROGRAM_CMD]; // R14
              d.ctl[fcr_pkg::CTL_OPTION_ERASE_CMD] = cd[fcr_pkg::CTL_OPTION_ERASE_CMD]; // R14
            end
          end
        end
        fcr_pkg::OFF_ADDR: d.addr = merge(q.addr, q.w_d, q.w_s); // R16
        default: d.b_r = fcr_pkg::RESP_SLVERR;
      endcase
    end

    // reads answer one cycle after the address is taken
    if (q.r_v && axi_req.rready) d.r_v = 1'b0;
    if (axi_req.arvalid && !q.r_v) begin
      d.r_v = 1'b1;
      d.r_r = fcr_pkg::RESP_OKAY;
      case (axi_req.araddr[11:0])
        fcr_pkg::OFF_WS:     d.r_d = {29'h0, q.wcnt};
        fcr_pkg::OFF_KEY:    d.r_d = 32'h0000_0000; // R26
        fcr_pkg::OFF_OPTION_KEY_VALUE:  d.r_d = 32'h0000_0000; // R26
        fcr_pkg::OFF_STAT:   d.r_d = {26'h0, q.stat[5:2], 1'b0, busy}; // R8
        fcr_pkg::OFF_CTL:    d.r_d = {18'h0, 1'b0, q.ctl[12:0]};
        fcr_pkg::OFF_ADDR:   d.r_d = q.addr;
        fcr_pkg::OFF_OBSTAT: d.r_d = q.obstat; // R17 R18 R19
        fcr_pkg::OFF_WP:     d.r_d = {16'h0, q.wp}; // R20
        fcr_pkg::OFF_PID:    d.r_d = PRODUCT_ID; // R21
        default: begin
          d.r_d = 32'h0000_0000;
          d.r_r = fcr_pkg::RESP_SLVERR;
        end
      endcase
    end

    // operation launch and completion
    case (q.fsm)
      fcr_pkg::FSM_IDLE: begin
        if (q.ctl[fcr_pkg::CTL_START]) begin
          d.op.addr = q.addr; // R16
          d.op.data = 32'h0000_0000;
          if (q.ctl[fcr_pkg::CTL_MER]) d.op.kind = fcr_pkg::OP_MER;
          else if (q.ctl[fcr_pkg::CTL_PER]) d.op.kind = fcr_pkg::OP_PER;
          else d.op.kind = fcr_pkg::OP_OPTION_ERASE_CMD;
          if ((q.ctl[fcr_pkg::CTL_MER] && (q.wp != 16'hFFFF))
              || (!q.ctl[fcr_pkg::CTL_MER] && q.ctl[fcr_pkg::CTL_PER]
                  && is_prot(q.addr, q.wp))) begin
            d.stat[fcr_pkg::ST_PROTECT_ERROR_FLAG] = 1'b1; // R5 R23
            d.ctl[fcr_pkg::CTL_START] = 1'b0; // R13
          end else if (q.ctl[fcr_pkg::CTL_MER] || q.ctl[fcr_pkg::CTL_PER]
                       || q.ctl[fcr_pkg::CTL_OPTION_ERASE_CMD]) begin
            d.fsm      = fcr_pkg::FSM_BUSY; // R8
            d.op.valid = 1'b1;
          end else begin
            d.ctl[fcr_pkg::CTL_START] = 1'b0; // R13
          end
        end else if (prog_req.valid
                     && (q.ctl[fcr_pkg::CTL_PG] || q.ctl[fcr_pkg::CTL_OPTION_PROGRAM_CMD])) begin
          d.op.addr = prog_req.addr;
          d.op.data = prog_req.data;
          d.op.kind = q.ctl[fcr_pkg::CTL_PG] ? fcr_pkg::OP_PG : fcr_pkg::OP_OPTION_PROGRAM_CMD;
          if (prog_req.addr[0] || (!prog_req.half && prog_req.addr[1])) begin
            d.stat[fcr_pkg::ST_ALIGN_ERROR_FLAG] = 1'b1; // R6
          end else if (q.ctl[fcr_pkg::CTL_PG] && is_prot(prog_req.addr, q.wp)) begin
            d.stat[fcr_pkg::ST_PROTECT_ERROR_FLAG] = 1'b1; // R5 R23
          end else begin
            d.fsm      = fcr_pkg::FSM_BUSY; // R8
            d.op.valid = 1'b1;
          end
        end
      end
      fcr_pkg::FSM_BUSY: begin
        if (op_done) begin
          d.fsm = fcr_pkg::FSM_IDLE; // R8
          d.ctl[fcr_pkg::CTL_START] = 1'b0; // R13
          if (op_not_blank && ((q.op.kind == fcr_pkg::OP_PG)
                               || (q.op.kind == fcr_pkg::OP_OPTION_PROGRAM_CMD))) begin
            d.stat[fcr_pkg::ST_PROGRAM_ERROR_FLAG] = 1'b1; // R7
          end else begin
            d.stat[fcr_pkg::ST_OP_DONE_FLAG] = 1'b1; // R4
          end
        end
      end
      default: d.fsm = fcr_pkg::FSM_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  // option capture is a clocked load right after release, not a reset value
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      q          <= '0;
      q.ctl      <= fcr_pkg::CTL_RST; // R9
      q.wcnt     <= fcr_pkg::WS_RST;
      q.wp       <= 16'hFFFF;
      q.opt_load <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  a_done_irq_gate: assert property (irq_done |-> q.ctl[fcr_pkg::CTL_DONE_IRQ_ENABLE]
                                    && q.stat[fcr_pkg::ST_OP_DONE_FLAG]) // R11
    else $error("done interrupt without enable");
  a_err_irq_gate: assert property (!q.ctl[fcr_pkg::CTL_ERROR_IRQ_ENABLE] |-> !irq_error) // R12
    else $error("error interrupt without enable");
  a_start_clears: assert property ($fell(busy) |-> !q.ctl[fcr_pkg::CTL_START]) // R13
    else $error("start still set after busy cleared");
  a_busy_ends: assert property (busy && op_done |=> !busy
    && (q.stat[fcr_pkg::ST_OP_DONE_FLAG] || q.stat[fcr_pkg::ST_PROGRAM_ERROR_FLAG])) // R8
    else $error("operation end not reported");
  a_launch_busy: assert property (q.op.valid |-> busy ##1 !q.op.valid) // R8
    else $error("launch pulse without busy");
  a_lock_holds: assert property (wr_go && q.aw_a == fcr_pkg::OFF_CTL
    && q.ctl[fcr_pkg::CTL_LK] |=> $stable(q.ctl[2:0])) // R24
    else $error("command bits changed while locked");
  a_key_unlock: assert property (wr_go && q.aw_a == fcr_pkg::OFF_KEY && q.key_half
    && q.w_s == 4'hF && q.w_d == UNLOCK_KEY2 |=> !q.ctl[fcr_pkg::CTL_LK]) // R2
    else $error("key pair did not unlock");
  a_align_err: assert property (!busy && !q.ctl[fcr_pkg::CTL_START] && prog_req.valid
    && q.ctl[fcr_pkg::CTL_PG] && prog_req.addr[0]
    |=> q.stat[fcr_pkg::ST_ALIGN_ERROR_FLAG] && !busy) // R6
    else $error("misaligned write not flagged");
  a_reload_reset: assert property (wr_go && q.aw_a == fcr_pkg::OFF_CTL && q.w_s[1]
    && q.w_d[fcr_pkg::CTL_OPTION_RELOAD] |=> sys_reset_req ##1 !sys_reset_req) // R10
    else $error("reload did not request reset");

  c_unlock: cover property (q.ctl[fcr_pkg::CTL_LK] ##1 !q.ctl[fcr_pkg::CTL_LK]);
  c_prog_done: cover property (q.op.valid && q.op.kind == fcr_pkg::OP_PG
                               ##[1:50] irq_done);
  c_prot_err: cover property ($rose(q.stat[fcr_pkg::ST_PROTECT_ERROR_FLAG]));
  c_reload: cover property (sys_reset_req);

endmodule

/* File: verilog/fcr_pkg.sv */
// shared constants and carriers of the flash control register block
// assumes a 32-bit axi4-lite master and a flash array engine on clk_sys
package fcr_pkg;

  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] OFF_WS     = 12'h000;
  localparam logic [11:0] OFF_KEY    = 12'h004;
  localparam logic [11:0] OFF_OPTION_KEY_VALUE  = 12'h008;
  localparam logic [11:0] OFF_STAT   = 12'h00C;
  localparam logic [11:0] OFF_CTL    = 12'h010;
  localparam logic [11:0] OFF_ADDR   = 12'h014;
  localparam logic [11:0] OFF_OBSTAT = 12'h01C;
  localparam logic [11:0] OFF_WP     = 12'h020;
  localparam logic [11:0] OFF_PID    = 12'h100;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int CTL_PG = 0, CTL_PER = 1, CTL_MER = 2, CTL_OPTION_PROGRAM_CMD = 4;
  localparam int CTL_OPTION_ERASE_CMD = 5, CTL_START = 6, CTL_LK = 7, CTL_OPTION_WRITE_ENABLE = 9;
  localparam int CTL_ERROR_IRQ_ENABLE = 10, CTL_DONE_IRQ_ENABLE = 12, CTL_OPTION_RELOAD = 13;
  localparam int ST_BUSY = 0, ST_PROGRAM_ERROR_FLAG = 2, ST_ALIGN_ERROR_FLAG = 3, ST_PROTECT_ERROR_FLAG = 4;
  localparam int ST_OP_DONE_FLAG = 5;
  localparam logic [13:0] CTL_RST = 14'h0080;
  localparam logic [2:0]  WS_RST  = 3'h0;
  localparam logic [7:0]  SPC_NONE = 8'hA5;
  localparam logic [7:0]  SPC_HIGH = 8'hCC;
  localparam logic [1:0]  RESP_OKAY = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef enum logic [0:0] {FSM_IDLE = 1'b0, FSM_BUSY = 1'b1} fcr_fsm_t;
  typedef enum logic [2:0] {
    OP_NONE = 3'b000, OP_PG = 3'b001, OP_PER = 3'b010, OP_MER = 3'b011,
    OP_OPTION_PROGRAM_CMD = 3'b100, OP_OPTION_ERASE_CMD = 3'b101
  } fcr_kind_t;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic awvalid; logic [31:0] awaddr;
    logic wvalid;  logic [31:0] wdata; logic [3:0] wstrb;
    logic bready;
    logic arvalid; logic [31:0] araddr;
    logic rready;
  } fcr_axi_req_t;

  typedef struct packed {
    logic awready; logic wready;
    logic bvalid;  logic [1:0] bresp;
    logic arready;
    logic rvalid;  logic [31:0] rdata; logic [1:0] rresp;
  } fcr_axi_rsp_t;

  typedef struct packed {
    logic valid; logic half; logic [31:0] addr; logic [31:0] data;
  } fcr_prog_t;

  typedef struct packed {
    logic valid; fcr_kind_t kind; logic [31:0] addr; logic [31:0] data;
  } fcr_op_t;

  typedef struct packed {
    fcr_fsm_t    fsm;
    logic [2:0]  wcnt;
    logic [13:0] ctl;
    logic [5:0]  stat;
    logic [31:0] addr;
    logic        key_half;
    logic        okey_half;
    logic [31:0] obstat;
    logic [15:0] wp;
    logic        opt_load;
    logic        rst_req;
    logic        aw_v;
    logic [11:0] aw_a;
    logic        w_v;
    logic [31:0] w_d;
    logic [3:0]  w_s;
    logic        b_v;
    logic [1:0]  b_r;
    logic        r_v;
    logic [31:0] r_d;
    logic [1:0]  r_r;
    fcr_op_t     op;
  } fcr_state_t;

endpackage
